// >>> ssp_pkg.sv
// Shared constants for the synchronous serial slave port and its external master.
// Assumes both ends run from one 40 MHz system clock, pclk.
package ssp_pkg;
  // System clock period and derived link timing.
  localparam int CLK_NS         = 25;
  localparam int CK_HALF_NS     = 250;
  localparam int CK_HALF_CYC    = (CK_HALF_NS + CLK_NS - 1) / CLK_NS;
  // Device register indices (8-bit registers).
  localparam logic [2:0] REG_TX_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] REG_RX_STATUS_CONTROL = 3'h1;
  localparam logic [2:0] REG_TRANSMIT_DATA     = 3'h2;
  localparam logic [2:0] REG_RECEIVE_DATA      = 3'h3;
  localparam logic [2:0] REG_INT_CONTROL       = 3'h4;
  localparam logic [2:0] REG_BAUD_DIVISOR_LOW  = 3'h5;
  localparam logic [2:0] REG_BAUD_DIVISOR_HIGH = 3'h6;
  localparam logic [2:0] REG_BAUD_CONTROL      = 3'h7;
  localparam logic [7:0] CTL_RESET             = 8'h00;
  // Transmit status/control fields.
  localparam int TXC_CLK_SRC = 7;
  localparam int TXC_NINE    = 6;
  localparam int TXC_EN      = 5;
  localparam int TXC_SYNC    = 4;
  localparam int TXC_EMPTY   = 1;
  localparam int TXC_NINTH   = 0;
  // Receive status/control fields.
  localparam int RXC_PORT_EN = 7;
  localparam int RXC_NINE    = 6;
  localparam int RXC_SINGLE  = 5;
  localparam int RXC_CONT    = 4;
  localparam int RXC_OVERRUN = 1;
  localparam int RXC_NINTH   = 0;
  // Interrupt flag and enable fields.
  localparam int INT_RX_FLAG   = 0;
  localparam int INT_TX_FLAG   = 1;
  localparam int INT_RX_EN     = 2;
  localparam int INT_TX_EN     = 3;
  localparam int INT_PERI_EN   = 4;
  localparam int INT_GLOBAL_EN = 5;
  // Master controller APB byte addresses and fields.
  localparam logic [3:0] MREG_CTRL   = 4'h0;
  localparam logic [3:0] MREG_TXDATA = 4'h4;
  localparam logic [3:0] MREG_STATUS = 4'h8;
  localparam logic [3:0] MREG_RXDATA = 4'hC;
  localparam int MCTL_GO    = 0;
  localparam int MCTL_NINE  = 1;
  localparam int MCTL_DRIVE = 2;
  localparam int MST_BUSY   = 0;
  localparam int MST_DONE   = 1;

  // Index of the last bit of a character.
  function automatic logic [3:0] ssp_last_idx(input logic nine);
    ssp_last_idx = nine ? 4'h8 : 4'h7;
  endfunction : ssp_last_idx
endpackage : ssp_pkg

// >>> ssp_link_if.sv
// Link between the serial port (slave) and the external synchronous master.
// Assumes an idle-high pull on the data line when neither end drives it.
`timescale 1ns/1ps
interface ssp_link_if;
  logic ck;
  logic dev_ck_oe_n;
  logic dev_dt_o;
  logic dev_dt_oe_n;
  logic mst_dt_o;
  logic mst_dt_oe_n;
  logic dt;

  // Resolved data line level.
  assign dt = !dev_dt_oe_n ? dev_dt_o : (!mst_dt_oe_n ? mst_dt_o : 1'b1);

  modport dev (input ck, input dt, output dev_ck_oe_n, output dev_dt_o, output dev_dt_oe_n);
  modport mst (output ck, output mst_dt_o, output mst_dt_oe_n, input dt);
endinterface : ssp_link_if

// >>> ssp_sync.sv
// Two-flop synchroniser with edge detection on a third stage.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/1ps
module ssp_sync #(
  parameter int W = 1
) (
  // System
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Asynchronous inputs
  input  wire logic [W-1:0] din,
  // Synchronised outputs
  output logic [W-1:0]      level,
  output logic [W-1:0]      rise,
  output logic [W-1:0]      fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } ssp_sync_t;

  ssp_sync_t r_r;
  ssp_sync_t r_nxt;

  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = din;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign level = r_r.s2;
  assign rise  = r_r.s2 & ~r_r.s3;
  assign fall  = ~r_r.s2 & r_r.s3;
endmodule : ssp_sync

// >>> ssp_dev_end.sv
// Synchronous slave serial port: register port, transmit path, two-deep receive buffer.
// Assumes the external master owns the shift clock; all link inputs are resynchronised to pclk.
//
// Implementation choices: register access over a plain address and read/write strobe port, and the placing of the registers.
`timescale 1ns/1ps
module ssp_dev_end
  import ssp_pkg::*;
(
  // System
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Events
  output logic            wake,
  output logic            vector,
  // Link
  ssp_link_if.dev         link
);
  typedef struct packed {
    logic [7:0]      tx_ctl;
    logic [7:0]      rx_ctl;
    logic [7:0]      int_ctl;
    logic [7:0]      baud_lo;
    logic [7:0]      baud_hi;
    logic [7:0]      baud_ctl;
    logic [8:0]      txbuf;
    logic            txbuf_v;
    logic [8:0]      transmit_shift_register;
    logic            tx_busy;
    logic [3:0]      tx_idx;
    logic            dt_o;
    logic            dt_oe_n;
    logic [8:0]      receive_shift_register;
    logic [3:0]      rx_idx;
    logic [1:0][8:0] fifo;
    logic [1:0]      fcnt;
    logic            overrun_error_flag;
    logic [7:0]      rdata;
    logic            wake;
    logic            vector;
  } ssp_dev_t;

  ssp_dev_t   r_r;
  ssp_dev_t   r_nxt;
  logic [1:0] s_level;
  logic [1:0] s_rise;
  logic [1:0] s_fall;

  // Index 1 is the shift clock, index 0 the data line.
  ssp_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({link.ck, link.dt}),
    .level   (s_level),
    .rise    (s_rise),
    .fall    (s_fall)
  );

  always_comb begin
    logic active;
    logic rx_mode;
    logic tx_on;
    logic rx_on;
    logic transmit_buffer_empty_flag;
    logic receive_ready_flag;
    active  = 1'b0;
    rx_mode = 1'b0;
    tx_on   = 1'b0;
    rx_on   = 1'b0;
    transmit_buffer_empty_flag    = 1'b0;
    receive_ready_flag    = 1'b0;
    r_nxt   = r_r;

    active  = r_r.rx_ctl[RXC_PORT_EN] & r_r.tx_ctl[TXC_SYNC] & ~r_r.tx_ctl[TXC_CLK_SRC];
    rx_mode = r_r.rx_ctl[RXC_SINGLE] | r_r.rx_ctl[RXC_CONT];
    tx_on   = active & r_r.tx_ctl[TXC_EN] & ~rx_mode;
    rx_on   = active & rx_mode;

    // Register writes.
    if (reg_wr) begin
      unique case (reg_addr)
        REG_TX_STATUS_CONTROL: r_nxt.tx_ctl = reg_wdata & 8'hF1;
        REG_RX_STATUS_CONTROL: r_nxt.rx_ctl = reg_wdata & 8'hF0;
        REG_TRANSMIT_DATA: begin
          r_nxt.txbuf   = {r_r.tx_ctl[TXC_NINE] & r_r.tx_ctl[TXC_NINTH], reg_wdata};
          r_nxt.txbuf_v = 1'b1;
        end
        REG_RECEIVE_DATA:      r_nxt.rdata = r_r.rdata;
        REG_INT_CONTROL:       r_nxt.int_ctl = reg_wdata & 8'h3C;
        REG_BAUD_DIVISOR_LOW:  r_nxt.baud_lo = reg_wdata;
        REG_BAUD_DIVISOR_HIGH: r_nxt.baud_hi = reg_wdata;
        REG_BAUD_CONTROL:      r_nxt.baud_ctl = reg_wdata;
      endcase
    end

    // Transmit shifting on the external clock.
    // drive on leading edge
    if (tx_on && r_r.tx_busy && s_rise[1]) begin
      r_nxt.dt_o = r_r.transmit_shift_register[r_r.tx_idx];
    end
    if (tx_on && r_r.tx_busy && s_fall[1]) begin
      if (r_r.tx_idx == ssp_last_idx(r_r.tx_ctl[TXC_NINE])) begin
        r_nxt.tx_busy = 1'b0;
      end else begin
        r_nxt.tx_idx = r_r.tx_idx + 4'h1;
      end
    end
    // load shift register, then flag empty
    if (tx_on && !r_r.tx_busy && r_r.txbuf_v && !(reg_wr && reg_addr == REG_TRANSMIT_DATA)) begin
      r_nxt.transmit_shift_register     = r_r.txbuf;
      r_nxt.tx_busy = 1'b1;
      r_nxt.tx_idx  = 4'h0;
      r_nxt.txbuf_v = 1'b0;
      r_nxt.dt_o    = r_r.txbuf[0];
    end
    if (!tx_on) begin
      r_nxt.tx_busy = 1'b0;
      r_nxt.tx_idx  = 4'h0;
    end
    r_nxt.dt_oe_n = ~tx_on;

    // Receive buffer pop on data read.
    if (reg_rd && reg_addr == REG_RECEIVE_DATA && r_r.fcnt != 2'h0) begin
      r_nxt.fifo[0] = r_r.fifo[1];
      r_nxt.fcnt    = r_r.fcnt - 2'h1;
    end
    if (!rx_on) begin
      r_nxt.rx_idx = 4'h0;
    end else if (s_fall[1] && !r_r.overrun_error_flag) begin
      r_nxt.receive_shift_register[r_r.rx_idx] = s_level[0];
      if (r_r.rx_idx == ssp_last_idx(r_r.rx_ctl[RXC_NINE])) begin
        r_nxt.rx_idx = 4'h0;
        if (r_nxt.fcnt == 2'h2) begin
          r_nxt.overrun_error_flag = 1'b1;
        end else begin
          r_nxt.fifo[r_nxt.fcnt[0]] = {r_r.rx_ctl[RXC_NINE] & s_level[0], r_nxt.receive_shift_register[7:0]};
          r_nxt.fcnt                = r_nxt.fcnt + 2'h1;
        end
      end else begin
        r_nxt.rx_idx = r_r.rx_idx + 4'h1;
      end
    end
    if (!r_r.rx_ctl[RXC_CONT]) begin
      r_nxt.overrun_error_flag = 1'b0;
    end

    // port disable resets the shift and buffer state
    if (!r_r.rx_ctl[RXC_PORT_EN]) begin
      r_nxt.txbuf_v = 1'b0;
      r_nxt.tx_busy = 1'b0;
      r_nxt.tx_idx  = 4'h0;
      r_nxt.rx_idx  = 4'h0;
      r_nxt.fcnt    = 2'h0;
      r_nxt.overrun_error_flag    = 1'b0;
    end

    // Register reads.
    transmit_buffer_empty_flag = ~r_r.txbuf_v;
    receive_ready_flag = r_r.fcnt != 2'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_TX_STATUS_CONTROL: begin
          r_nxt.rdata            = r_r.tx_ctl;
          r_nxt.rdata[TXC_EMPTY] = ~r_r.tx_busy;
        end
        REG_RX_STATUS_CONTROL: begin
          r_nxt.rdata              = r_r.rx_ctl;
          r_nxt.rdata[RXC_OVERRUN] = r_r.overrun_error_flag;
          r_nxt.rdata[RXC_NINTH]   = r_r.fifo[0][8];
        end
        REG_TRANSMIT_DATA:     r_nxt.rdata = 8'h00;
        REG_RECEIVE_DATA:      r_nxt.rdata = r_r.fifo[0][7:0];
        REG_INT_CONTROL: begin
          r_nxt.rdata              = r_r.int_ctl;
          r_nxt.rdata[INT_RX_FLAG] = receive_ready_flag;
          r_nxt.rdata[INT_TX_FLAG] = transmit_buffer_empty_flag;
        end
        REG_BAUD_DIVISOR_LOW:  r_nxt.rdata = r_r.baud_lo;
        REG_BAUD_DIVISOR_HIGH: r_nxt.rdata = r_r.baud_hi;
        REG_BAUD_CONTROL:      r_nxt.rdata = r_r.baud_ctl;
      endcase
    end

    r_nxt.wake   = (transmit_buffer_empty_flag & r_r.int_ctl[INT_TX_EN] & r_r.int_ctl[INT_PERI_EN])
                 | (receive_ready_flag & r_r.int_ctl[INT_RX_EN]);
    r_nxt.vector = r_nxt.wake & r_r.int_ctl[INT_GLOBAL_EN];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r          <= '0;
      r_r.tx_ctl   <= CTL_RESET;
      r_r.rx_ctl   <= CTL_RESET;
      r_r.int_ctl  <= CTL_RESET;
      r_r.dt_oe_n  <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign reg_rdata        = r_r.rdata;
  assign wake             = r_r.wake;
  assign vector           = r_r.vector;
  assign link.dev_dt_o    = r_r.dt_o;
  assign link.dev_dt_oe_n = r_r.dt_oe_n;
  assign link.dev_ck_oe_n = 1'b1;
endmodule : ssp_dev_end

// >>> ssp_mst_end.sv
// External synchronous master: APB-programmed, makes the shift clock by dividing pclk.
// Assumes a zero-wait-state-capable APB master and an idle-low shift clock.
`timescale 1ns/1ps
module ssp_mst_end
  import ssp_pkg::*;
#(
  parameter int HALF_CYC = CK_HALF_CYC
) (
  // System
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  ssp_link_if.mst          link
);
  typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH} ssp_mst_state_t;

  typedef struct packed {
    ssp_mst_state_t state;
    logic [7:0]     cnt;
    logic [3:0]     idx;
    logic           nine;
    logic           drive;
    logic           done;
    logic [8:0]     txd;
    logic [8:0]     rxd;
    logic           ck;
    logic           dt_o;
    logic           dt_oe_n;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
  } ssp_mst_t;

  ssp_mst_t r_r;
  ssp_mst_t r_nxt;
  logic     s_dt;

  ssp_sync #(.W(1)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (link.dt),
    .level   (s_dt),
    .rise    (),
    .fall    ()
  );

  always_comb begin
    logic setup;
    logic wr_go;
    logic mapped;
    setup  = psel & ~penable;
    wr_go  = psel & penable & r_r.pready & pwrite;
    mapped = paddr[31:4] == 28'h0 && paddr[1:0] == 2'h0;
    r_nxt  = r_r;

    // APB answers in the first access cycle.
    r_nxt.pready  = setup;
    r_nxt.pslverr = setup & ~mapped;
    if (setup) begin
      unique case (paddr[3:0])
        MREG_CTRL:   r_nxt.prdata = {29'h0, r_r.drive, r_r.nine, 1'b0};
        MREG_TXDATA: r_nxt.prdata = {23'h0, r_r.txd};
        MREG_STATUS: r_nxt.prdata = {30'h0, r_r.done, r_r.state != M_IDLE};
        MREG_RXDATA: r_nxt.prdata = {23'h0, r_r.rxd};
        default:     r_nxt.prdata = 32'h0;
      endcase
    end
    if (wr_go && mapped && paddr[3:0] == MREG_TXDATA && r_r.state == M_IDLE) begin
      r_nxt.txd = pwdata[8:0];
    end
    if (wr_go && mapped && paddr[3:0] == MREG_CTRL && r_r.state == M_IDLE) begin
      r_nxt.nine  = pwdata[MCTL_NINE];
      r_nxt.drive = pwdata[MCTL_DRIVE];
      if (pwdata[MCTL_GO]) begin
        r_nxt.state = M_LOW;
        r_nxt.cnt   = 8'(HALF_CYC - 1);
        r_nxt.idx   = 4'h0;
        r_nxt.done  = 1'b0;
        r_nxt.rxd   = 9'h000;
      end
    end

    // Clock generation; data changes at rise and is sampled at fall.
    unique case (r_r.state)
      M_IDLE: begin
        r_nxt.ck      = 1'b0;
        r_nxt.dt_oe_n = 1'b1;
      end
      M_LOW: begin
        if (r_r.cnt == 8'h00) begin
          r_nxt.state   = M_HIGH;
          r_nxt.cnt     = 8'(HALF_CYC - 1);
          r_nxt.ck      = 1'b1;
          r_nxt.dt_o    = r_r.txd[r_r.idx];
          r_nxt.dt_oe_n = ~r_r.drive;
        end else begin
          r_nxt.cnt = r_r.cnt - 8'h01;
        end
      end
      M_HIGH: begin
        if (r_r.cnt == 8'h00) begin
          r_nxt.ck           = 1'b0;
          r_nxt.rxd[r_r.idx] = s_dt;
          r_nxt.cnt          = 8'(HALF_CYC - 1);
          if (r_r.idx == ssp_last_idx(r_r.nine)) begin
            r_nxt.state = M_IDLE;
            r_nxt.done  = 1'b1;
          end else begin
            r_nxt.state = M_LOW;
            r_nxt.idx   = r_r.idx + 4'h1;
          end
        end else begin
          r_nxt.cnt = r_r.cnt - 8'h01;
        end
      end
      // The fourth state code is unused; fall back to idle with the clock low.
      default: begin
        r_nxt.state   = M_IDLE;
        r_nxt.ck      = 1'b0;
        r_nxt.dt_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r         <= '0;
      r_r.state   <= M_IDLE;
      r_r.dt_oe_n <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign prdata           = r_r.prdata;
  assign pready           = r_r.pready;
  assign pslverr          = r_r.pslverr;
  assign link.ck          = r_r.ck;
  assign link.mst_dt_o    = r_r.dt_o;
  assign link.mst_dt_oe_n = r_r.dt_oe_n;
endmodule : ssp_mst_end

// >>> ssp_link_properties.sv
// Link checker for the slave port facing its external master.
// Assumes both ends share pclk and the master half period is 8 cycles.
`timescale 1ns/1ps
module ssp_link_properties (
  // System
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic ck,
  input wire logic dev_ck_oe_n,
  input wire logic dev_dt_o,
  input wire logic dev_dt_oe_n,
  input wire logic mst_dt_o,
  input wire logic mst_dt_oe_n,
  input wire logic dt
);
  logic       ck_d_r;
  logic [4:0] idle_r;
  logic [3:0] bits_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Counts clock falls per burst; twelve low cycles close a burst.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_d_r <= 1'b0;
      idle_r <= 5'h00;
      bits_r <= 4'h0;
    end else begin
      ck_d_r <= ck;
      idle_r <= ck ? 5'h00 : idle_r + {4'h0, idle_r != 5'h1F};
      if (idle_r == 5'h0C) begin
        bits_r <= 4'h0;
      end else if (ck_d_r && !ck) begin
        bits_r <= bits_r + 4'h1;
      end
    end
  end

  ck_drive_off_a: assert property (dev_ck_oe_n)
    else $error("device drove the shift clock");
  single_driver_a: assert property (dev_dt_oe_n || mst_dt_oe_n)
    else $error("both ends drove the data line");
  ck_high_len_a: assert property ($rose(ck) |-> ck [*8] ##1 !ck)
    else $error("shift clock high phase not 8 cycles");
  ck_low_len_a: assert property ($fell(ck) |-> !ck [*8])
    else $error("shift clock low phase under 8 cycles");
  dev_setup_a: assert property ($fell(ck) && !dev_dt_oe_n |-> dt == $past(dev_dt_o, 3))
    else $error("device data not settled before trailing edge");
  dev_hold_a: assert property ($fell(ck) && !dev_dt_oe_n |-> $stable(dev_dt_o) [*3])
    else $error("device data changed at trailing edge");
  mst_hold_a: assert property ($fell(ck) && !mst_dt_oe_n |-> $stable(mst_dt_o) [*4])
    else $error("master data changed at trailing edge");
  burst_bits_a: assert property (idle_r == 5'h0C |-> bits_r inside {4'h0, 4'h8, 4'h9})
    else $error("burst clock count not 8 or 9");
endmodule : ssp_link_properties

// >>> tb.sv
// Bench joining the slave port and its external master across the link.
// Assumes pclk at 40 MHz and the master half period cut to 8 cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module tb;
  import ssp_pkg::*;
  typedef struct {string nm; logic [31:0] v;} ssp_note_t;
  logic        pclk = 1'b0;
  logic        presetn;
  logic [2:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        wake;
  logic        vector;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        err_seen = 1'b0;
  logic        rd_d = 1'b0;
  int          num_errors = 0;
  int          checks = 0;
  ssp_note_t   note_q[$];
  logic [7:0]  tx_tab [6] = '{8'h20, 8'hB0, 8'h30, 8'h30, 8'h30, 8'h30};
  logic [7:0]  rx_tab [6] = '{8'h80, 8'h80, 8'h00, 8'h90, 8'hA0, 8'h80};
  logic [5:0]  oe_tab = 6'b011111;
  logic [8:0]  c [3];
  logic [7:0]  rxc;
  logic        nine;

  ssp_link_if ssp_link_if_inst ();
  ssp_dev_end ssp_dev_end_inst (.pclk(pclk), .presetn(presetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wake(wake), .vector(vector),
    .link(ssp_link_if_inst));
  ssp_mst_end #(.HALF_CYC(8)) ssp_mst_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(ssp_link_if_inst));
  ssp_link_properties ssp_link_properties_inst (.pclk(pclk), .presetn(presetn), .ck(ssp_link_if_inst.ck),
    .dev_ck_oe_n(ssp_link_if_inst.dev_ck_oe_n), .dev_dt_o(ssp_link_if_inst.dev_dt_o),
    .dev_dt_oe_n(ssp_link_if_inst.dev_dt_oe_n), .mst_dt_o(ssp_link_if_inst.mst_dt_o),
    .mst_dt_oe_n(ssp_link_if_inst.mst_dt_oe_n), .dt(ssp_link_if_inst.dt));

  always #12.5 pclk = ~pclk;

  task automatic end_of_test();
    if (note_q.size() != 0) begin
      num_errors++;
      $display("unexpected results: expected %0d more seen none", note_q.size());
    end
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic hang();
    num_errors++;
    $display("unexpected wait: expected an answer seen none");
    end_of_test();
  endtask : hang

  task automatic expect_val(input string nm, input logic [31:0] v);
    note_q.push_back('{nm, v});
  endtask : expect_val

  task automatic take(input string src, input logic [31:0] g);
    ssp_note_t n;
    if (note_q.size() == 0) begin
      num_errors++;
      $display("unexpected %s: expected no result seen %h", src, g);
    end else begin
      n = note_q.pop_front();
      `CHK(n.nm, n.v, g)
    end
  endtask : take

  // Watches both read paths and pairs each result with the oldest note.
  always @(posedge pclk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) take("device read", {24'h0, reg_rdata});
    if (psel && penable && pready === 1'b1 && !pwrite) take("apb read", prdata);
  end

  task automatic dev_acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= wr;
    reg_rd    <= !wr;
    @(posedge pclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge pclk);
  endtask : dev_acc

  task automatic dev_rd(input logic [2:0] a, input logic [7:0] e);
    expect_val("device register", {24'h0, e});
    dev_acc(1'b0, a, 8'h00);
  endtask : dev_rd

  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {28'h0, a} | (a == 4'h1 ? 32'h10 : 32'h0);
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    err_seen = pslverr;
    if (n >= 64) hang();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic frame(input logic drv, input logic [8:0] d, input logic [8:0] rx);
    int n;
    int t;
    logic ck_d;
    apb(1'b1, MREG_TXDATA, {23'h0, d});
    apb(1'b1, MREG_CTRL, {29'h0, drv, nine, 1'b1});
    n = 0;
    t = 0;
    ck_d = 1'b0;
    while (n < (nine ? 9 : 8) && t < 4000) begin
      @(posedge pclk);
      t++;
      if (ck_d && !ssp_link_if_inst.ck) n++;
      ck_d = ssp_link_if_inst.ck;
    end
    if (t >= 4000) hang();
    repeat (8) @(posedge pclk);
    expect_val("master status", 32'h2);
    apb(1'b0, MREG_STATUS, 32'h0);
    expect_val("master rx", {23'h0, rx});
    apb(1'b0, MREG_RXDATA, 32'h0);
    `CHK("apb error", 1'b0, err_seen)
  endtask : frame

  initial begin
    {presetn, reg_addr, reg_wr, reg_rd, reg_wdata, psel, penable, pwrite, paddr, pwdata, nine} = '0;
    void'($urandom(54802));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    dev_rd(REG_TX_STATUS_CONTROL, 8'h02);
    dev_rd(REG_RX_STATUS_CONTROL, 8'h00);
    dev_rd(REG_INT_CONTROL, 8'h02);
    for (int i = 5; i < 8; i++) begin
      rxc = 8'($urandom);
      dev_acc(1'b1, 3'(i), rxc);
      dev_rd(3'(i), rxc);
    end
    expect_val("unmapped read", 32'h0);
    apb(1'b0, 4'h1, 32'h0);
    `CHK("apb error", 1'b1, err_seen)
    for (int i = 0; i < 6; i++) begin
      dev_acc(1'b1, REG_TX_STATUS_CONTROL, tx_tab[i]);
      dev_acc(1'b1, REG_RX_STATUS_CONTROL, rx_tab[i]);
      repeat (3) @(posedge pclk);
      `CHK("data drive", oe_tab[i], ssp_link_if_inst.dev_dt_oe_n)
    end
    dev_acc(1'b1, REG_INT_CONTROL, 8'h18);
    for (int nn = 0; nn < 2; nn++) begin
      nine = nn[0];
      for (int k = 0; k < 2; k++) begin
        c[k] = 9'($urandom) & (nine ? 9'h1FF : 9'h0FF);
        dev_acc(1'b1, REG_TX_STATUS_CONTROL, {1'b0, nine, 5'b11000, c[k][8]});
        dev_acc(1'b1, REG_TRANSMIT_DATA, c[k][7:0]);
      end
      repeat (3) @(posedge pclk);
      `CHK("wake", 1'b0, wake)
      dev_rd(REG_INT_CONTROL, 8'h18);
      frame(1'b0, 9'h000, c[0]);
      dev_rd(REG_INT_CONTROL, 8'h1A);
      `CHK("wake", 1'b1, wake)
      dev_acc(1'b1, REG_INT_CONTROL, 8'h38);
      repeat (3) @(posedge pclk);
      `CHK("vector", 1'b1, vector)
      dev_acc(1'b1, REG_INT_CONTROL, 8'h18);
      frame(1'b0, 9'h000, c[1]);
    end
    dev_acc(1'b1, REG_INT_CONTROL, 8'h04);
    for (int nn = 0; nn < 2; nn++) begin
      nine = nn[0];
      rxc = {1'b1, nine, nine, 5'b10000};
      dev_acc(1'b1, REG_TX_STATUS_CONTROL, 8'h10);
      dev_acc(1'b1, REG_RX_STATUS_CONTROL, rxc);
      for (int k = 0; k < 3; k++) begin
        c[k] = 9'($urandom) & (nine ? 9'h1FF : 9'h0FF);
        frame(1'b1, c[k], c[k]);
        if (k == 0) begin
          dev_rd(REG_INT_CONTROL, 8'h07);
          `CHK("wake", 1'b1, wake)
        end
      end
      dev_rd(REG_RX_STATUS_CONTROL, rxc | 8'h02 | {7'h0, c[0][8]});
      rxc = rxc & 8'hEF;
      dev_acc(1'b1, REG_RX_STATUS_CONTROL, rxc);
      dev_rd(REG_RX_STATUS_CONTROL, rxc | {7'h0, c[0][8]});
      dev_rd(REG_RECEIVE_DATA, c[0][7:0]);
      dev_rd(REG_RX_STATUS_CONTROL, rxc | {7'h0, c[1][8]});
      dev_rd(REG_RECEIVE_DATA, c[1][7:0]);
      dev_rd(REG_INT_CONTROL, 8'h06);
    end
    repeat (4) @(posedge pclk);
    end_of_test();
  end
endmodule : tb
